// ---- sbc_bank_cmd_legality.sv ----
`timescale 1ns/10ps
`include "sbc_defines.svh"

// Notes on behaviour
// - Refresh lasts tRC, then all banks idle
// - Mode load lasts tMRD, then all idle
// - Precharge-all lasts tRP, leaves banks idle
// - Precharge-all needs every bank prechargeable
// - Burst stop hits most recent burst only
// - Precharge to idle bank is a no-op
// - Inhibit and no-op continue current operation
// - Auto-precharge burst cut by read or write starts own precharge; burst stop leaves bank in its auto-precharge state
// - Read after read: new data CL later
// - Write cuts read; host masks one earlier
// - Read ends write; last word one before
// - Write ends write; last word one before
// - Read ends auto-precharge read; precharge immediately
// - Write ends auto-precharge read; precharge immediately
// - Read ends auto-precharge write; precharge after tWR
// - Write ends auto-precharge write; precharge after tWR
// - Bank states: idle, activating, active, read, write, auto-precharge read and write, precharge, write recovery
// - Auto-precharge bank stays until tRP, then idle
// - Commands count only with clock enable twice high
module sbc_bank_cmd_legality
  import sbc_pkg::*;
#(
  parameter int BURST_LEN = `SBC_BURST_LEN,
  parameter int CAS_LAT = `SBC_CAS_LAT
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [1:0] bankAddr,
  input wire logic autoPre,
  input wire logic dqm,
  output sbc_bank_t [`SBC_NUM_BANKS-1:0] bankState,
  output sbc_glob_t globalState,
  output logic rdValid,
  output logic [1:0] rdBank,
  output logic wrAccept,
  output logic [1:0] wrBank,
  output logic [`SBC_NUM_BANKS-1:0] prechargeStart,
  output logic illegalCmd
);

  localparam logic [3:0] TRP = 4'(`SBC_TRP_CYC);
  localparam logic [3:0] TRCD = 4'(`SBC_TRCD_CYC);
  localparam logic [3:0] TRC = 4'(`SBC_TRC_CYC);
  localparam logic [3:0] TMRD = 4'(`SBC_TMRD_CYC);
  localparam logic [3:0] TWR = 4'(`SBC_TWR_CYC);
  localparam logic [3:0] BL = 4'(BURST_LEN);

  sbc_state_t stQ;
  sbc_state_t stD;
  sbc_cmd_t cmd;
  logic cmdGo;
  logic allIdle;
  logic refAcc;
  logic mrlAcc;
  logic preAllAcc;
  logic preIdleAcc;
  logic rdAcc;
  logic wrAcc;
  logic apRdHit;
  logic apWrHit;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  always_comb begin
    if (csN) begin
      cmd = CMD_INHIBIT;
    end else begin
      cmd = sbc_cmd_t'({1'b0, rasN, casN, weN});
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [1:0] ob;
    stD = stQ;
    ob = stQ.burstBank;
    refAcc = 1'b0;
    mrlAcc = 1'b0;
    preAllAcc = 1'b0;
    preIdleAcc = 1'b0;
    rdAcc = 1'b0;
    wrAcc = 1'b0;
    apRdHit = 1'b0;
    apWrHit = 1'b0;
    stD.prStart = '0;
    stD.illegal = 1'b0;
    stD.wrAccept = 1'b0;
    stD.ckePrev = cke;
    allIdle = 1'b1;
    for (int b = 0; b < `SBC_NUM_BANKS; b++) begin
      if (stQ.bank[b] != BK_IDLE) begin
        allIdle = 1'b0;
      end
    end
    for (int b = 0; b < `SBC_NUM_BANKS; b++) begin
      if (stQ.bTmr[b] > 4'h1) begin
        stD.bTmr[b] = stQ.bTmr[b] - 4'h1;
      end else if (stQ.bank[b] == BK_ACTIVATING) begin
        stD.bank[b] = BK_ACTIVE;
      end else if (stQ.bank[b] == BK_PRECHG) begin
        stD.bank[b] = BK_IDLE;
      end else if (stQ.bank[b] == BK_WR_RECOV) begin
        stD.bank[b] = BK_PRECHG;
        stD.bTmr[b] = TRP;
        stD.prStart[b] = 1'b1;
      end
    end
    if (stQ.gst != GL_NORMAL) begin
      if (stQ.gTmr > 4'h1) begin
        stD.gTmr = stQ.gTmr - 4'h1;
      end else begin
        stD.gst = GL_NORMAL;
        for (int b = 0; b < `SBC_NUM_BANKS; b++) begin
          stD.bank[b] = BK_IDLE;
        end
      end
    end
    // Read pipeline shift
    stD.rdPipe = {stQ.rdPipe[`SBC_CL_MAX-2:0], 1'b0};
    stD.rdPipeBank = {stQ.rdPipeBank[`SBC_CL_MAX-2:0], 2'h0};
    stD.rdValid = stQ.rdPipe[CAS_LAT-1];
    stD.rdBank = stQ.rdPipeBank[CAS_LAT-1];
    // Burst progress; natural end of an auto-precharge burst
    if (stQ.burstOn) begin
      if (stQ.burstCnt >= BL) begin
        stD.burstOn = 1'b0;
        if (stQ.bank[ob] == BK_READ || stQ.bank[ob] == BK_WRITE) begin
          stD.bank[ob] = BK_ACTIVE;
        end else if (stQ.bank[ob] == BK_READ_AP) begin
          stD.bank[ob] = BK_PRECHG;
          stD.bTmr[ob] = TRP;
          stD.prStart[ob] = 1'b1;
        end else if (stQ.bank[ob] == BK_WRITE_AP) begin
          stD.bank[ob] = BK_WR_RECOV;
          stD.bTmr[ob] = TWR;
        end
      end else begin
        stD.burstCnt = stQ.burstCnt + 4'h1;
        if (stQ.burstWr) begin
          stD.wrAccept = ~dqm;
          stD.wrBank = ob;
        end else begin
          stD.rdPipe[0] = 1'b1;
          stD.rdPipeBank[0] = ob;
        end
      end
    end
    // only with clock enable high at both edges
    // inhibit and no-op fall through untouched
    cmdGo = stQ.ckePrev && cke && cmd != CMD_INHIBIT && cmd != CMD_NOP;
    if (cmdGo && stQ.gst != GL_NORMAL) begin
      // flag commands during a global state
      stD.illegal = 1'b1;
    end else if (cmdGo) begin
      unique case (cmd)
        CMD_ACTIVE: begin
          if (stQ.bank[bankAddr] == BK_IDLE) begin
            stD.bank[bankAddr] = BK_ACTIVATING;
            stD.bTmr[bankAddr] = TRCD;
          end else begin
            stD.illegal = 1'b1;
          end
        end
        CMD_READ, CMD_WRITE: begin
          if (stQ.bank[bankAddr] inside {BK_ACTIVE, BK_READ, BK_WRITE}) begin
            rdAcc = (cmd == CMD_READ);
            wrAcc = (cmd == CMD_WRITE);
            if (stQ.burstOn) begin
              // interrupted burst hands over its bank
              if (stQ.bank[ob] == BK_READ_AP) begin
                apRdHit = 1'b1;
                stD.bank[ob] = BK_PRECHG;
                stD.bTmr[ob] = TRP;
                stD.prStart[ob] = 1'b1;
              end else if (stQ.bank[ob] == BK_WRITE_AP) begin
                apWrHit = 1'b1;
                stD.bank[ob] = BK_WR_RECOV;
                stD.bTmr[ob] = TWR;
              end else begin
                stD.bank[ob] = BK_ACTIVE;
              end
            end
            if (autoPre) begin
              stD.bank[bankAddr] = wrAcc ? BK_WRITE_AP : BK_READ_AP;
            end else begin
              stD.bank[bankAddr] = wrAcc ? BK_WRITE : BK_READ;
            end
            stD.burstOn = 1'b1;
            stD.burstWr = wrAcc;
            stD.burstBank = bankAddr;
            stD.burstCnt = 4'h1;
            if (wrAcc) begin
              // a write drops every read word in flight
              stD.rdPipe = '0;
              stD.rdValid = 1'b0;
              // old write word at this edge is not taken
              stD.wrAccept = ~dqm;
              stD.wrBank = bankAddr;
            end else begin
              // new read replaces older words CL later
              stD.wrAccept = 1'b0;
              stD.rdPipe[0] = 1'b1;
              stD.rdPipeBank[0] = bankAddr;
            end
          end else begin
            stD.illegal = 1'b1;
          end
        end
        CMD_PRECHARGE: begin
          if (autoPre) begin
            // every bank must be in a prechargeable state
            for (int b = 0; b < `SBC_NUM_BANKS; b++) begin
              if (stQ.bank[b] inside {BK_ACTIVATING, BK_READ_AP, BK_WRITE_AP,
                                      BK_WR_RECOV}) begin
                stD.illegal = 1'b1;
              end
            end
            if (!stD.illegal) begin
              preAllAcc = 1'b1;
              stD.gst = GL_PRE_ALL;
              stD.gTmr = TRP;
              stD.burstOn = 1'b0;
              for (int b = 0; b < `SBC_NUM_BANKS; b++) begin
                if (stQ.bank[b] != BK_IDLE) begin
                  stD.bank[b] = BK_PRECHG;
                  stD.bTmr[b] = TRP;
                  stD.prStart[b] = 1'b1;
                end
              end
            end
          end else if (stQ.bank[bankAddr] == BK_IDLE) begin
            // no effect on an idle bank
            preIdleAcc = 1'b1;
          end else if (stQ.bank[bankAddr] inside {BK_ACTIVE, BK_READ, BK_WRITE}) begin
            stD.bank[bankAddr] = BK_PRECHG;
            stD.bTmr[bankAddr] = TRP;
            stD.prStart[bankAddr] = 1'b1;
            if (stQ.burstOn && ob == bankAddr) begin
              stD.burstOn = 1'b0;
            end
          end else if (stQ.bank[bankAddr] != BK_PRECHG) begin
            stD.illegal = 1'b1;
          end
        end
        CMD_REFRESH, CMD_MODE_LOAD: begin
          // not bank-specific, all banks must be idle
          if (!allIdle) begin
            stD.illegal = 1'b1;
          end else if (cmd == CMD_REFRESH) begin
            refAcc = 1'b1;
            stD.gst = GL_REFRESH;
            stD.gTmr = TRC;
          end else begin
            mrlAcc = 1'b1;
            stD.gst = GL_MODE_LOAD;
            stD.gTmr = TMRD;
          end
        end
        CMD_BURST_STOP: begin
          // acts on the latest burst whatever the bank
          if (stQ.burstOn) begin
            stD.burstOn = 1'b0;
            stD.wrAccept = 1'b0;
            stD.rdPipe[0] = 1'b0;
            if (stQ.bank[ob] == BK_READ || stQ.bank[ob] == BK_WRITE) begin
              stD.bank[ob] = BK_ACTIVE;
            end
          end
        end
        default: begin
          stD.illegal = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stQ <= '0;
    end else begin
      stQ <= stD;
    end
  end

  assign bankState = stQ.bank;
  assign globalState = stQ.gst;
  assign rdValid = stQ.rdValid;
  assign rdBank = stQ.rdBank;
  assign wrAccept = stQ.wrAccept;
  assign wrBank = stQ.wrBank;
  assign prechargeStart = stQ.prStart;
  assign illegalCmd = stQ.illegal;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  localparam int TRC_C = `SBC_TRC_CYC;
  localparam int TMRD_C = `SBC_TMRD_CYC;
  localparam int TRP_C = `SBC_TRP_CYC;
  localparam int TWR_D = `SBC_TWR_CYC + 1;
  localparam int CL_C = CAS_LAT;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_refresh_len: assert property (
    refAcc |=> globalState == GL_REFRESH ##[TRC_C:TRC_C] globalState == GL_NORMAL)
    else $error("refresh state length wrong");
  chk_mode_len: assert property (
    mrlAcc |=> globalState == GL_MODE_LOAD ##[TMRD_C:TMRD_C] globalState == GL_NORMAL)
    else $error("mode load state length wrong");
  chk_preall_idle: assert property (
    preAllAcc |-> ##[TRP_C:TRP_C] ##1 (globalState == GL_NORMAL && bankState == '0))
    else $error("precharge-all did not leave banks idle");
  chk_pre_idle_nop: assert property (
    preIdleAcc |=> bankState[$past(bankAddr)] == BK_IDLE && !illegalCmd)
    else $error("precharge changed an idle bank");
  chk_read_latency: assert property (
    rdAcc |-> ##[CL_C:CL_C] ##1 (rdValid && rdBank == $past(bankAddr, CL_C + 1)))
    else $error("read data not at CAS latency");
  chk_write_cuts_read: assert property (
    wrAcc |=> !rdValid && wrAccept == !$past(dqm))
    else $error("write did not cut read");
  chk_ap_read_pre: assert property (
    apRdHit |=> prechargeStart != '0)
    else $error("auto-precharge read not precharged");
  chk_ap_write_pre: assert property (
    apWrHit |-> ##[TWR_D:TWR_D] prechargeStart != '0)
    else $error("auto-precharge write recovery wrong");
  chk_busy_flag: assert property (
    (cmdGo && globalState != GL_NORMAL) |=> illegalCmd)
    else $error("command in global state not flagged");

  cov_read_read: cover property (rdAcc ##1 rdAcc);
  cov_write_after_read: cover property (rdAcc ##1 wrAcc);
  cov_ap_interrupt: cover property (apWrHit);
  cov_refresh: cover property (refAcc);

endmodule // sbc_bank_cmd_legality

// ---- sbc_defines.svh ----
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SBC_CLK_MHZ 40
`define SBC_TRP_NS 20
`define SBC_TRCD_NS 20
`define SBC_TRC_NS 66
`define SBC_TMRD_NS 15
`define SBC_TWR_NS 15
// Least times round up to whole cycles
`define SBC_NS2CYC(ns) ((((ns) * `SBC_CLK_MHZ) + 999) / 1000)
`define SBC_TRP_CYC `SBC_NS2CYC(`SBC_TRP_NS)
`define SBC_TRCD_CYC `SBC_NS2CYC(`SBC_TRCD_NS)
`define SBC_TRC_CYC `SBC_NS2CYC(`SBC_TRC_NS)
`define SBC_TMRD_CYC `SBC_NS2CYC(`SBC_TMRD_NS)
`define SBC_TWR_CYC `SBC_NS2CYC(`SBC_TWR_NS)

// ----------------------------------------
// Burst and read pipeline
// ----------------------------------------
`define SBC_BURST_LEN 4
`define SBC_CAS_LAT 2
`define SBC_CL_MAX 3
`define SBC_NUM_BANKS 4

`endif

// ---- sbc_pkg.sv ----
`include "sbc_defines.svh"

package sbc_pkg;

  typedef enum logic [3:0] {
    BK_IDLE = 4'h0,
    BK_ACTIVATING = 4'h1,
    BK_ACTIVE = 4'h2,
    BK_READ = 4'h3,
    BK_WRITE = 4'h4,
    BK_READ_AP = 4'h5,
    BK_WRITE_AP = 4'h6,
    BK_PRECHG = 4'h7,
    BK_WR_RECOV = 4'h8
  } sbc_bank_t;

  typedef enum logic [1:0] {
    GL_NORMAL = 2'h0,
    GL_REFRESH = 2'h1,
    GL_MODE_LOAD = 2'h2,
    GL_PRE_ALL = 2'h3
  } sbc_glob_t;

  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'h8,
    CMD_NOP = 4'h7,
    CMD_ACTIVE = 4'h3,
    CMD_READ = 4'h5,
    CMD_WRITE = 4'h4,
    CMD_PRECHARGE = 4'h2,
    CMD_REFRESH = 4'h1,
    CMD_MODE_LOAD = 4'h0,
    CMD_BURST_STOP = 4'h6
  } sbc_cmd_t;

  typedef struct packed {
    sbc_bank_t [`SBC_NUM_BANKS-1:0] bank;
    logic [`SBC_NUM_BANKS-1:0][3:0] bTmr;
    sbc_glob_t gst;
    logic [3:0] gTmr;
    logic burstOn;
    logic burstWr;
    logic [1:0] burstBank;
    logic [3:0] burstCnt;
    logic [`SBC_CL_MAX-1:0] rdPipe;
    logic [`SBC_CL_MAX-1:0][1:0] rdPipeBank;
    logic rdValid;
    logic [1:0] rdBank;
    logic wrAccept;
    logic [1:0] wrBank;
    logic [`SBC_NUM_BANKS-1:0] prStart;
    logic illegal;
    logic ckePrev;
  } sbc_state_t;

endpackage

// ---- sbc_host_model.sv ----
`timescale 1ns/10ps
module sbc_host_model
  import sbc_pkg::*;
(
  input wire logic core_clk,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [1:0] bankAddr,
  output logic autoPre,
  output logic dqm
);
  // ----------------------------------------
  // Command pins
  // ----------------------------------------
  initial begin
    {csN, rasN, casN, weN} = CMD_NOP;
    bankAddr = 2'h0;
    autoPre = 1'b0;
    dqm = 1'b1;
  end

  task automatic issue(input sbc_cmd_t c, input logic [1:0] b, input logic ap, input logic dm);
    {csN, rasN, casN, weN} = c;
    bankAddr = b;
    autoPre = ap;
    dqm = dm;
    @(posedge core_clk);
    #1;
  endtask

  // no-ops between commands, mask raised
  // Unused lines keep moving so the design cannot lean on stale values
  task automatic idle(input int n);
    repeat (n) begin
      {csN, rasN, casN, weN} = CMD_NOP;
      bankAddr = ~bankAddr;
      autoPre = ~autoPre;
      dqm = 1'b1;
      @(posedge core_clk);
      #1;
    end
  endtask
endmodule // sbc_host_model

// ---- sbc_bank_cmd_legality_tb.sv ----
`timescale 1ns/10ps
module sbc_bank_cmd_legality_tb
  import sbc_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic cke = 1'b1;
  logic csN, rasN, casN, weN, autoPre, dqm;
  logic [1:0] bankAddr;
  sbc_bank_t [3:0] bankState;
  sbc_glob_t globalState;
  logic rdValid, wrAccept, illegalCmd;
  logic [1:0] rdBank, wrBank;
  logic [3:0] prechargeStart;
  int numErrors = 0;
  int compares = 0;

  always #12.5 core_clk = ~core_clk;

  sbc_bank_cmd_legality i_dut (.core_clk(core_clk), .nrst(nrst), .cke(cke), .csN(csN),
    .rasN(rasN), .casN(casN), .weN(weN), .bankAddr(bankAddr), .autoPre(autoPre), .dqm(dqm),
    .bankState(bankState), .globalState(globalState), .rdValid(rdValid), .rdBank(rdBank),
    .wrAccept(wrAccept), .wrBank(wrBank), .prechargeStart(prechargeStart),
    .illegalCmd(illegalCmd));

  sbc_host_model i_host (.core_clk(core_clk), .csN(csN), .rasN(rasN), .casN(casN),
    .weN(weN), .bankAddr(bankAddr), .autoPre(autoPre), .dqm(dqm));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input sbc_cmd_t c, input logic [1:0] b, input logic ap, input logic dm);
    i_host.issue(c, b, ap, dm);
  endtask

  task automatic nop(input int n);
    i_host.idle(n);
  endtask

  task automatic act(input logic [1:0] b);
    cmd(CMD_ACTIVE, b, 1'b0, 1'b1);
    chk("activating", BK_ACTIVATING, bankState[b]);
    nop(1);
    chk("active", BK_ACTIVE, bankState[b]);
  endtask

  task automatic completeRun;
    if (numErrors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_global;
    sbc_cmd_t c [3] = '{CMD_REFRESH, CMD_MODE_LOAD, CMD_PRECHARGE};
    sbc_glob_t g [3] = '{GL_REFRESH, GL_MODE_LOAD, GL_PRE_ALL};
    int d [3] = '{3, 1, 1};
    for (int i = 0; i < 3; i++) begin
      if (i == 2) act(2'h3);
      cmd(c[i], 2'h1, i == 2, 1'b1);
      for (int k = 0; k < d[i]; k++) begin
        chk("global busy", g[i], globalState);
        if (k == 1) begin
          cmd(CMD_ACTIVE, 2'h2, 1'b0, 1'b1);
          chk("busy refusal", 1'b1, illegalCmd);
        end else begin
          nop(1);
        end
      end
      chk("global end", GL_NORMAL, globalState);
      chk("all idle", 16'h0000, bankState);
    end
  endtask

  task automatic t_rdrd;
    act(2'h0);
    act(2'h1);
    cmd(CMD_REFRESH, 2'h0, 1'b0, 1'b1);
    chk("refresh refused", 1'b1, illegalCmd);
    chk("no refresh", GL_NORMAL, globalState);
    cmd(CMD_READ, 2'h0, 1'b0, 1'b1);
    cmd(CMD_READ, 2'h1, 1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      nop(1);
      chk("read valid", i < 5, rdValid);
      if (i < 5) chk("read bank", i > 0, rdBank);
    end
    chk("bank0 ends", BK_ACTIVE, bankState[0]);
  endtask

  task automatic t_wrrd;
    cmd(CMD_WRITE, 2'h0, 1'b0, 1'b0);
    chk("write word", 1'b1, wrAccept);
    chk("write bank", 2'h0, wrBank);
    cmd(CMD_READ, 2'h1, 1'b0, 1'b0);
    chk("word dropped", 1'b0, wrAccept);
    nop(2);
    chk("read after cl", 1'b1, rdValid);
    chk("read bank", 2'h1, rdBank);
  endtask

  task automatic t_wapwr;
    cmd(CMD_WRITE, 2'h0, 1'b1, 1'b0);
    chk("write ap", BK_WRITE_AP, bankState[0]);
    cmd(CMD_WRITE, 2'h1, 1'b0, 1'b0);
    chk("recovery", BK_WR_RECOV, bankState[0]);
    chk("no pre yet", 1'b0, prechargeStart[0]);
    nop(1);
    chk("pre after twr", 1'b1, prechargeStart[0]);
    nop(1);
    chk("ap idle", BK_IDLE, bankState[0]);
  endtask

  task automatic t_rapd;
    act(2'h0);
    cmd(CMD_READ, 2'h0, 1'b1, 1'b1);
    cmd(CMD_READ, 2'h1, 1'b0, 1'b1);
    chk("pre at read", 1'b1, prechargeStart[0]);
    chk("precharging", BK_PRECHG, bankState[0]);
    nop(1);
    chk("idle after trp", BK_IDLE, bankState[0]);
    nop(1);
    chk("new data", 1'b1, rdValid);
    chk("new bank", 2'h1, rdBank);
  endtask

  task automatic t_misc;
    cmd(CMD_PRECHARGE, 2'h0, 1'b0, 1'b1);
    chk("idle pre quiet", 1'b0, illegalCmd);
    chk("idle pre state", BK_IDLE, bankState[0]);
    act(2'h2);
    cmd(CMD_READ, 2'h2, 1'b0, 1'b1);
    cmd(CMD_INHIBIT, 2'h3, 1'b1, 1'b0);
    chk("inhibit quiet", 1'b0, illegalCmd);
    chk("inhibit global", GL_NORMAL, globalState);
    nop(1);
    chk("burst goes on", 1'b1, rdValid);
    cmd(CMD_BURST_STOP, 2'h3, 1'b0, 1'b1);
    chk("stop own bank", BK_ACTIVE, bankState[2]);
    chk("stop other", BK_IDLE, bankState[3]);
    cke = 1'b0;
    nop(1);
    cke = 1'b1;
    cmd(CMD_ACTIVE, 2'h3, 1'b0, 1'b1);
    chk("cke gate", BK_IDLE, bankState[3]);
    nop(1);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    nop(2);
    chk("reset banks", 16'h0000, bankState);
    chk("reset global", GL_NORMAL, globalState);
    t_global();
    t_rdrd();
    t_wrrd();
    t_wapwr();
    t_rapd();
    t_misc();
    completeRun();
  end

  // Whole run needs well under 100 cycles; 400 leaves room
  initial begin
    #(25 * 400);
    numErrors++;
    completeRun();
  end
endmodule // sbc_bank_cmd_legality_tb
